// File: common/mls_pkg.sv
package mls_pkg;
    localparam int BUS_W = 64;
    localparam int REG_W = 40;
    localparam int SW_W = 16;
    localparam int NW_W = 32;
    localparam int FILL_W = 8;
    localparam int EXT_W = 16;
    localparam int ROWS_W = 2 * BUS_W;
    localparam int LANES = ROWS_W / SW_W;
    localparam int SW_IMPL_LANE = 2;
    localparam int NW_IMPL_LANE = 1;
    localparam int NBUS = 2;
    localparam int BUS_PM = 0;
    localparam int BUS_DM = 1;
    localparam int NSLOT = 2;
    localparam int SLOT_EX = 0;
    localparam int SLOT_IM = 1;

    typedef enum logic [1:0] {
        MLS_SHORT,
        MLS_NORMAL,
        MLS_EXTENDED,
        MLS_LONG
    } mls_width_t;

    typedef logic [REG_W-1:0] mls_reg_t;
    typedef logic [BUS_W-1:0] mls_bus_t;
    typedef logic [ROWS_W-1:0] mls_rows_t;
    typedef logic [LANES-1:0] mls_lanes_t;

    typedef struct packed {
        logic [NBUS-1:0][BUS_W-1:0] bus;
        logic [NBUS-1:0][ROWS_W-1:0] wrData;
        logic [NBUS-1:0][LANES-1:0] wrLaneEn;
        logic [NBUS-1:0][REG_W-1:0] priLoad;
        logic [NBUS-1:0][REG_W-1:0] secLoad;
        logic [NBUS-1:0] priWe;
        logic [NBUS-1:0] secWe;
        logic done;
        logic errDirect;
        logic errMix;
        logic errUnsup;
    } mls_state_t;

    localparam mls_state_t MLS_STATE_RST = '0;
endpackage : mls_pkg

// File: common/mls_fmt_if.sv
interface mls_fmt_if;
    logic isShort;
    logic short_sign_extend_bit;
    logic [mls_pkg::NW_W-1:0] memWord;
    logic [mls_pkg::REG_W-1:0] loadReg;
    logic [mls_pkg::REG_W-1:0] storeReg;
    logic [mls_pkg::NW_W-1:0] storeWord;

    modport core (
        output isShort,
        output short_sign_extend_bit,
        output memWord,
        output storeReg,
        input loadReg,
        input storeWord
    );

    modport conv (
        input isShort,
        input short_sign_extend_bit,
        input memWord,
        input storeReg,
        output loadReg,
        output storeWord
    );
endinterface : mls_fmt_if

// File: core/mls_word_format.sv
module mls_word_format (
    mls_fmt_if.conv fmt
);
    import mls_pkg::*;

    logic [EXT_W-1:0] ext;

    always_comb begin
        // one sign-extend control serves both elements alike
        ext = fmt.short_sign_extend_bit ? {EXT_W{fmt.memWord[SW_W-1]}} : '0;
        if (fmt.isShort) begin
            fmt.loadReg = {ext, fmt.memWord[SW_W-1:0], {FILL_W{1'b0}}};
            fmt.storeWord = {{(NW_W-SW_W){1'b0}}, fmt.storeReg[FILL_W +: SW_W]};
        end else begin
            fmt.loadReg = {fmt.memWord, {FILL_W{1'b0}}};
            // low fill bits are dropped, not rounded
            fmt.storeWord = fmt.storeReg[FILL_W +: NW_W];
        end
    end
endmodule // mls_word_format

// File: core/mls_lane_steer.sv
module mls_lane_steer (
    input wire logic clk,
    input wire logic rst,
    input wire logic reqValid,
    input wire logic reqDual,
    input wire logic reqSimd,
    input wire logic reqStore,
    input wire logic reqDirect,
    input wire logic reqUseDm,
    input wire logic short_sign_extend_bit,
    input wire mls_pkg::mls_width_t widthPm,
    input wire mls_pkg::mls_width_t widthDm,
    input wire logic [1:0] addrPm,
    input wire logic [1:0] addrDm,
    input wire logic exSecPm,
    input wire logic exSecDm,
    input wire mls_pkg::mls_reg_t priStorePm,
    input wire mls_pkg::mls_reg_t secStorePm,
    input wire mls_pkg::mls_reg_t priStoreDm,
    input wire mls_pkg::mls_reg_t secStoreDm,
    input wire mls_pkg::mls_rows_t rowsPm,
    input wire mls_pkg::mls_rows_t rowsDm,
    output mls_pkg::mls_bus_t pmBus,
    output mls_pkg::mls_bus_t dmBus,
    output mls_pkg::mls_rows_t pmWrData,
    output mls_pkg::mls_rows_t dmWrData,
    output mls_pkg::mls_lanes_t pmWrLaneEn,
    output mls_pkg::mls_lanes_t dmWrLaneEn,
    output mls_pkg::mls_reg_t priLoadPm,
    output mls_pkg::mls_reg_t secLoadPm,
    output mls_pkg::mls_reg_t priLoadDm,
    output mls_pkg::mls_reg_t secLoadDm,
    output logic priWePm,
    output logic secWePm,
    output logic priWeDm,
    output logic secWeDm,
    output logic done,
    output logic errDirect,
    output logic errMix,
    output logic errUnsup
);
    import mls_pkg::*;

    localparam int NFMT = NBUS * NSLOT;

    function automatic logic [SW_W-1:0] swPick(input mls_rows_t rows, input logic [2:0] idx);
        return rows[idx*SW_W +: SW_W];
    endfunction

    function automatic logic [NW_W-1:0] nwPick(input mls_rows_t rows, input logic [1:0] idx);
        return rows[idx*NW_W +: NW_W];
    endfunction

    function automatic logic isNarrow(input mls_width_t w);
        return (w == MLS_SHORT) || (w == MLS_NORMAL);
    endfunction

    mls_state_t state_r;
    mls_state_t state_nxt;

    mls_width_t wid [NBUS];
    logic [NBUS-1:0][1:0] adr;
    logic [NBUS-1:0] exSec;
    logic [NBUS-1:0][REG_W-1:0] priS;
    logic [NBUS-1:0][REG_W-1:0] secS;
    logic [NBUS-1:0][ROWS_W-1:0] rows;

    logic [NBUS-1:0][2:0] exSw;
    logic [NBUS-1:0][2:0] imSw;
    logic [NBUS-1:0][1:0] exNw;
    logic [NBUS-1:0][1:0] imNw;

    logic [NFMT-1:0] fmtShort;
    logic [NFMT-1:0][NW_W-1:0] fmtMem;
    logic [NFMT-1:0][REG_W-1:0] fmtStore;
    logic [NFMT-1:0][REG_W-1:0] fmtLoad;
    logic [NFMT-1:0][NW_W-1:0] fmtWord;

    assign wid[BUS_PM] = widthPm;
    assign wid[BUS_DM] = widthDm;
    assign adr = {addrDm, addrPm};
    assign exSec = {exSecDm, exSecPm};
    assign priS = {priStoreDm, priStorePm};
    assign secS = {secStoreDm, secStorePm};
    // each bus sees its row plus the following row, so an implicit
    // word past the end of a row is still reachable
    assign rows = {rowsDm, rowsPm};

    for (genvar g = 0; g < NFMT; g++) begin : gFmt
        mls_fmt_if fi ();
        assign fi.isShort = fmtShort[g];
        assign fi.short_sign_extend_bit = short_sign_extend_bit;
        assign fi.memWord = fmtMem[g];
        assign fi.storeReg = fmtStore[g];
        assign fmtLoad[g] = fi.loadReg;
        assign fmtWord[g] = fi.storeWord;
        mls_word_format uFmt (
            .fmt(fi)
        );
    end

    always_comb begin : pAddr
        for (int b = 0; b < NBUS; b++) begin
            exSw[b] = {1'b0, adr[b]};
            imSw[b] = exSw[b] + 3'h1;
            exNw[b] = {1'b0, adr[b][0]};
            imNw[b] = exNw[b] + 2'h1;
        end
    end

    always_comb begin : pFmtIn
        for (int b = 0; b < NBUS; b++) begin
            fmtShort[b*NSLOT+SLOT_EX] = (wid[b] == MLS_SHORT);
            fmtShort[b*NSLOT+SLOT_IM] = (wid[b] == MLS_SHORT);
            if (wid[b] == MLS_SHORT) begin
                fmtMem[b*NSLOT+SLOT_EX] = {{(NW_W-SW_W){1'b0}}, swPick(rows[b], exSw[b])};
                fmtMem[b*NSLOT+SLOT_IM] = {{(NW_W-SW_W){1'b0}}, swPick(rows[b], imSw[b])};
            end else begin
                fmtMem[b*NSLOT+SLOT_EX] = nwPick(rows[b], exNw[b]);
                fmtMem[b*NSLOT+SLOT_IM] = nwPick(rows[b], imNw[b]);
            end
            // a named secondary register makes the primary one implicit
            fmtStore[b*NSLOT+SLOT_EX] = exSec[b] ? secS[b] : priS[b];
            fmtStore[b*NSLOT+SLOT_IM] = exSec[b] ? priS[b] : secS[b];
        end
    end

    logic [NBUS-1:0] active;
    logic [NBUS-1:0] narrow;
    logic dualDirect;
    logic mixBad;
    logic unsup;
    logic go;
    logic [NW_W-1:0] exW;
    logic [NW_W-1:0] imW;

    always_comb begin : pNext
        state_nxt = MLS_STATE_RST;
        exW = '0;
        imW = '0;
        for (int b = 0; b < NBUS; b++) begin
            narrow[b] = isNarrow(wid[b]);
            active[b] = reqDual | (reqUseDm == (b == BUS_DM));
        end
        dualDirect = reqValid & reqDual & reqDirect;
        mixBad = reqValid & reqDual & reqSimd & (narrow[BUS_PM] != narrow[BUS_DM]);
        // width is judged per bus; only extended/long are not steered here
        unsup = reqValid & |(active & ~narrow);
        go = reqValid & ~dualDirect & ~mixBad & ~unsup;
        state_nxt.done = reqValid;
        state_nxt.errDirect = dualDirect;
        state_nxt.errMix = mixBad & ~dualDirect;
        state_nxt.errUnsup = unsup & ~dualDirect & ~mixBad;
        for (int b = 0; b < NBUS; b++) begin
            if (go && active[b]) begin
                exW = reqStore ? fmtWord[b*NSLOT+SLOT_EX] : fmtMem[b*NSLOT+SLOT_EX];
                imW = reqStore ? fmtWord[b*NSLOT+SLOT_IM] : fmtMem[b*NSLOT+SLOT_IM];
                if (wid[b] == MLS_SHORT) begin
                    // lanes left untouched stay zero from the default
                    state_nxt.bus[b][0 +: SW_W] = exW[SW_W-1:0];
                    if (reqSimd) begin
                        state_nxt.bus[b][SW_IMPL_LANE*SW_W +: SW_W] = imW[SW_W-1:0];
                    end
                    if (reqStore) begin
                        state_nxt.wrData[b][exSw[b]*SW_W +: SW_W] = exW[SW_W-1:0];
                        state_nxt.wrLaneEn[b][exSw[b]] = 1'b1;
                        if (reqSimd) begin
                            state_nxt.wrData[b][imSw[b]*SW_W +: SW_W] = imW[SW_W-1:0];
                            state_nxt.wrLaneEn[b][imSw[b]] = 1'b1;
                        end
                    end
                end else begin
                    state_nxt.bus[b][0 +: NW_W] = exW;
                    if (reqSimd) begin
                        state_nxt.bus[b][NW_IMPL_LANE*NW_W +: NW_W] = imW;
                    end
                    if (reqStore) begin
                        state_nxt.wrData[b][exNw[b]*NW_W +: NW_W] = exW;
                        state_nxt.wrLaneEn[b][exNw[b]*2 +: 2] = 2'h3;
                        if (reqSimd) begin
                            state_nxt.wrData[b][imNw[b]*NW_W +: NW_W] = imW;
                            state_nxt.wrLaneEn[b][imNw[b]*2 +: 2] = 2'h3;
                        end
                    end
                end
                if (!reqStore) begin
                    if (exSec[b]) begin
                        state_nxt.secLoad[b] = fmtLoad[b*NSLOT+SLOT_EX];
                        state_nxt.secWe[b] = 1'b1;
                    end else begin
                        state_nxt.priLoad[b] = fmtLoad[b*NSLOT+SLOT_EX];
                        state_nxt.priWe[b] = 1'b1;
                    end
                    if (reqSimd) begin
                        if (exSec[b]) begin
                            state_nxt.priLoad[b] = fmtLoad[b*NSLOT+SLOT_IM];
                            state_nxt.priWe[b] = 1'b1;
                        end else begin
                            state_nxt.secLoad[b] = fmtLoad[b*NSLOT+SLOT_IM];
                            state_nxt.secWe[b] = 1'b1;
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= MLS_STATE_RST;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign pmBus = state_r.bus[BUS_PM];
    assign dmBus = state_r.bus[BUS_DM];
    assign pmWrData = state_r.wrData[BUS_PM];
    assign dmWrData = state_r.wrData[BUS_DM];
    assign pmWrLaneEn = state_r.wrLaneEn[BUS_PM];
    assign dmWrLaneEn = state_r.wrLaneEn[BUS_DM];
    assign priLoadPm = state_r.priLoad[BUS_PM];
    assign secLoadPm = state_r.secLoad[BUS_PM];
    assign priLoadDm = state_r.priLoad[BUS_DM];
    assign secLoadDm = state_r.secLoad[BUS_DM];
    assign priWePm = state_r.priWe[BUS_PM];
    assign secWePm = state_r.secWe[BUS_PM];
    assign priWeDm = state_r.priWe[BUS_DM];
    assign secWeDm = state_r.secWe[BUS_DM];
    assign done = state_r.done;
    assign errDirect = state_r.errDirect;
    assign errMix = state_r.errMix;
    assign errUnsup = state_r.errUnsup;
endmodule // mls_lane_steer

// File: testbench/mls_mem_model.sv
module mls_mem_model (
    input wire logic flip,
    output mls_pkg::mls_rows_t rowsPm,
    output mls_pkg::mls_rows_t rowsDm
);
    timeunit 1ns;
    timeprecision 1ps;
    import mls_pkg::*;
    // rows answer at once; flip turns sign bits round for extension cases
    assign rowsPm = {128{flip}} ^ 128'h9a8b_7c6d_f5e4_3d2c_c1b0_2f1e_8d7c_4b3a;
    assign rowsDm = {128{flip}} ^ 128'h1234_e5f6_a7b8_69c0_d1e2_03f4_b516_7788;
endmodule // mls_mem_model

// File: testbench/mls_lane_steer_monitor.sv
module mls_lane_steer_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic reqValid,
    input wire logic reqDual,
    input wire logic reqSimd,
    input wire logic reqStore,
    input wire logic reqDirect,
    input wire logic reqUseDm,
    input wire logic short_sign_extend_bit,
    input wire mls_pkg::mls_width_t widthPm,
    input wire mls_pkg::mls_width_t widthDm,
    input wire logic exSecDm,
    input wire mls_pkg::mls_bus_t pmBus,
    input wire mls_pkg::mls_bus_t dmBus,
    input wire mls_pkg::mls_reg_t priLoadDm,
    input wire mls_pkg::mls_reg_t secLoadDm,
    input wire logic priWeDm,
    input wire logic secWeDm,
    input wire logic errDirect,
    input wire logic errMix
);
    timeunit 1ns;
    timeprecision 1ps;
    import mls_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence s_ldDm;
        reqValid && !reqDual && !reqStore && reqUseDm && widthDm == MLS_SHORT;
    endsequence
    sequence s_sisdLd;
        s_ldDm ##0 !reqSimd && !exSecDm;
    endsequence
    sequence s_simdLd;
        s_ldDm ##0 reqSimd && !exSecDm;
    endsequence
    property p_ldZero;
        s_ldDm |=> dmBus[31:16] == '0 && dmBus[63:48] == '0 && pmBus == '0;
    endproperty
    a_ldZero: assert property (p_ldZero) else $error("unused short lane not zero");
    property p_ldLow;
        s_ldDm |=> priLoadDm[7:0] == '0 && secLoadDm[7:0] == '0;
    endproperty
    a_ldLow: assert property (p_ldLow) else $error("short load low byte not zero");
    property p_ext;
        s_sisdLd |=> priWeDm && priLoadDm[39:24] == ($past(short_sign_extend_bit) ? {16{priLoadDm[23]}} : 16'h0);
    endproperty
    a_ext: assert property (p_ext) else $error("short load upper fill wrong");
    property p_pair;
        s_simdLd |=> priWeDm && secWeDm && priLoadDm[23:8] == dmBus[15:0]
            && secLoadDm[23:8] == dmBus[47:32];
    endproperty
    a_pair: assert property (p_pair) else $error("implicit target pairing wrong");
    property p_sisd;
        s_sisdLd |=> dmBus[47:16] == '0 && !secWeDm;
    endproperty
    a_sisd: assert property (p_sisd) else $error("sisd short not on lane zero");
    property p_direct;
        reqValid && reqDual && reqDirect |=> errDirect && pmBus == '0 && dmBus == '0;
    endproperty
    a_direct: assert property (p_direct) else $error("direct dual not refused");
    property p_mix;
        reqValid && reqDual && reqSimd && !reqDirect
            && (widthPm inside {MLS_SHORT, MLS_NORMAL}) != (widthDm inside {MLS_SHORT, MLS_NORMAL})
            |=> errMix;
    endproperty
    a_mix: assert property (p_mix) else $error("simd width mix not refused");
    property p_any;
        reqValid && reqDual && !reqSimd && !reqDirect |=> !errMix && !errDirect;
    endproperty
    a_any: assert property (p_any) else $error("sisd dual mix refused");
endmodule // mls_lane_steer_monitor

bind mls_lane_steer mls_lane_steer_monitor u_mon (
    .clk, .rst, .reqValid, .reqDual, .reqSimd, .reqStore, .reqDirect, .reqUseDm, .short_sign_extend_bit,
    .widthPm, .widthDm, .exSecDm, .pmBus, .dmBus, .priLoadDm, .secLoadDm, .priWeDm,
    .secWeDm, .errDirect, .errMix
);

// File: testbench/mls_lane_steer_bench.sv
module mls_lane_steer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import mls_pkg::*;
    logic clk = 0, rst = 1, flip = 0, short_sign_extend_bit = 0, exSecPm = 0, exSecDm = 0;
    logic reqValid = 0, reqDual = 0, reqSimd = 0, reqStore = 0, reqDirect = 0, reqUseDm = 0;
    logic [1:0] addrPm = 0, addrDm = 0;
    mls_width_t widthPm = MLS_SHORT, widthDm = MLS_SHORT;
    mls_reg_t priStorePm = 40'hab_cdef_1234, secStorePm = 40'h11_2233_4455;
    mls_reg_t priStoreDm = 40'h56_7890_fedc, secStoreDm = 40'h66_7788_99aa;
    mls_rows_t rowsPm, rowsDm, pmWrData, dmWrData;
    mls_bus_t pmBus, dmBus;
    mls_lanes_t pmWrLaneEn, dmWrLaneEn;
    mls_reg_t priLoadPm, secLoadPm, priLoadDm, secLoadDm;
    logic priWePm, secWePm, priWeDm, secWeDm, done, errDirect, errMix, errUnsup;
    int failCount = 0, checksDone = 0, cyc = 0;
    mls_mem_model mem (.flip, .rowsPm, .rowsDm);
    mls_lane_steer dut (
        .clk, .rst, .reqValid, .reqDual, .reqSimd, .reqStore, .reqDirect, .reqUseDm, .short_sign_extend_bit,
        .widthPm, .widthDm, .addrPm, .addrDm, .exSecPm, .exSecDm, .priStorePm, .secStorePm,
        .priStoreDm, .secStoreDm, .rowsPm, .rowsDm, .pmBus, .dmBus, .pmWrData, .dmWrData,
        .pmWrLaneEn, .dmWrLaneEn, .priLoadPm, .secLoadPm, .priLoadDm, .secLoadDm, .priWePm,
        .secWePm, .priWeDm, .secWeDm, .done, .errDirect, .errMix, .errUnsup
    );
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic testDone();
        if (failCount == 0 && checksDone > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            failCount++;
            testDone();
        end
    end
    task automatic cmp(string nm, logic [127:0] e, logic [127:0] g);
        checksDone++;
        if (g !== e) begin
            failCount++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    function automatic mls_reg_t ld(logic [15:0] w, logic s);
        return {{16{s & w[15]}}, w, 8'h00};
    endfunction
    // one request, answer sampled one cycle later, just after the edge that registers it
    task automatic go(logic d, s, st, dr, u, mls_width_t wp, wd, logic [1:0] ap, ad, logic xd);
        @(posedge clk);
        #1;
        {reqValid, reqDual, reqSimd, reqStore, reqDirect, reqUseDm} = {1'b1, d, s, st, dr, u};
        widthPm = wp;
        widthDm = wd;
        addrPm = ap;
        addrDm = ad;
        exSecDm = xd;
        @(posedge clk);
        #1;
        reqValid = 0;
        cmp("done", 1, done);
    endtask
    task automatic tShortSisd();
        logic [15:0] w;
        for (int a = 0; a < 4; a++) begin
            short_sign_extend_bit = a[0];
            go(0, 0, 0, 0, 0, MLS_SHORT, MLS_SHORT, a[1:0], 0, 0);
            w = rowsPm[16*a +: 16];
            cmp("pmBus", {48'h0, w}, pmBus);
            cmp("priLoadPm", ld(w, short_sign_extend_bit), priLoadPm);
            cmp("we", {2'b10, 64'h0}, {priWePm, secWePm, dmBus});
            go(0, 0, 0, 0, 1, MLS_SHORT, MLS_SHORT, 0, a[1:0], 0);
            w = rowsDm[16*a +: 16];
            cmp("dmBus", {48'h0, w}, dmBus);
            cmp("priLoadDm", ld(w, short_sign_extend_bit), priLoadDm);
            cmp("weDm", {2'b10, 64'h0}, {priWeDm, secWeDm, pmBus});
        end
    endtask
    task automatic tShortSimd();
        logic [15:0] w0, w1;
        for (int a = 0; a < 4; a++) begin
            short_sign_extend_bit = 1;
            flip = a[1];
            go(0, 1, 0, 0, 1, MLS_SHORT, MLS_SHORT, 0, a[1:0], a[0]);
            w0 = rowsDm[16*a +: 16];
            w1 = rowsDm[16*(a+1) +: 16];
            cmp("dmBus", {16'h0, w1, 16'h0, w0}, dmBus);
            cmp("expl", ld(w0, 1), a[0] ? secLoadDm : priLoadDm);
            cmp("impl", ld(w1, 1), a[0] ? priLoadDm : secLoadDm);
        end
    endtask
    task automatic tNormal();
        logic [31:0] w0, w1;
        for (int i = 0; i < 4; i++) begin
            go(0, i[1], 0, 0, 0, MLS_NORMAL, MLS_SHORT, {1'b0, i[0]}, 0, 0);
            w0 = rowsPm[32*i[0] +: 32];
            w1 = rowsPm[32*(i[0]+1) +: 32];
            cmp("pmBus", i[1] ? {w1, w0} : {32'h0, w0}, pmBus);
            cmp("priLoadPm", {w0, 8'h00}, priLoadPm);
        end
    endtask
    task automatic tStore();
        go(0, 0, 1, 0, 0, MLS_NORMAL, MLS_SHORT, 1, 0, 0);
        cmp("pmBus", {32'h0, priStorePm[39:8]}, pmBus);
        cmp("pmWr", {8'h0c, priStorePm[39:8]}, {pmWrLaneEn, pmWrData[63:32]});
        go(0, 0, 1, 0, 1, MLS_SHORT, MLS_SHORT, 0, 2, 0);
        cmp("dmBus", {48'h0, priStoreDm[23:8]}, dmBus);
        cmp("dmWr", {8'h04, priStoreDm[23:8]}, {dmWrLaneEn, dmWrData[47:32]});
    endtask
    task automatic tDual();
        flip = 0;
        go(1, 1, 0, 0, 0, MLS_SHORT, MLS_SHORT, 0, 0, 0);
        cmp("pmBus", {16'h0, rowsPm[31:16], 16'h0, rowsPm[15:0]}, pmBus);
        cmp("dmBus", {16'h0, rowsDm[31:16], 16'h0, rowsDm[15:0]}, dmBus);
        go(1, 0, 0, 0, 0, MLS_NORMAL, MLS_NORMAL, 0, 0, 0);
        cmp("buses", {32'h0, rowsPm[31:0], 32'h0, rowsDm[31:0]}, {pmBus, dmBus});
        go(1, 0, 0, 0, 0, MLS_SHORT, MLS_NORMAL, 0, 0, 0);
        cmp("buses", {48'h0, rowsPm[15:0], 32'h0, rowsDm[31:0]}, {pmBus, dmBus});
        go(1, 1, 0, 0, 0, MLS_SHORT, MLS_NORMAL, 0, 0, 0);
        cmp("dmBus", rowsDm[63:0], dmBus);
        go(1, 1, 0, 0, 0, MLS_SHORT, MLS_EXTENDED, 0, 0, 0);
        cmp("err", {3'b010, 64'h0}, {errDirect, errMix, errUnsup, pmBus});
        go(1, 0, 0, 1, 0, MLS_SHORT, MLS_SHORT, 0, 0, 0);
        cmp("err", {3'b100, 64'h0}, {errDirect, errMix, errUnsup, dmBus});
        go(0, 0, 0, 0, 0, MLS_LONG, MLS_SHORT, 0, 0, 0);
        cmp("err", 3'b001, {errDirect, errMix, errUnsup});
    endtask
    initial begin
        repeat (3) @(posedge clk);
        #1;
        rst = 0;
        tShortSisd();
        tShortSimd();
        tNormal();
        tStore();
        tDual();
        testDone();
    end
endmodule // mls_lane_steer_bench
